// ---- bseu_exec.sv ----
// execution unit: register change, branch group and compare-and-skip group
`timescale 1ns/1ns
`include "bseu_consts.svh"
module bseu_exec
    import bseu_pkg::*;
#(
    parameter logic [5:0] OP_BRANCH_UNCONDITIONAL   = 6'h01,
    parameter logic [5:0] OP_INCREMENT_INDEX_BRANCH = 6'h21,
    parameter logic [5:0] OP_SKIP_IF_EQUAL          = 6'h28,
    parameter logic [5:0] OP_SKIP_IF_GREATER        = 6'h3B,
    parameter logic [5:0] OP_SKIP_MASKED_EQUAL      = 6'h38,
    parameter logic [5:0] OP_SKIP_NO_COMMON_ONES    = 6'h3A
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [13:0] mem_addr_o,
    output logic      [23:0] mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic [23:0] mem_rdata_i,
    output logic             int_clear_o,
    output logic             int_block_o
);

    function automatic logic [23:0] bseu_wr24(input logic [23:0] old, input logic [31:0] d,
                                              input logic [3:0] sel);
        logic [23:0] r;
        begin
            r = old;
            if (sel[0]) r[7:0] = d[7:0];
            if (sel[1]) r[15:8] = d[15:8];
            if (sel[2]) r[23:16] = d[23:16];
            bseu_wr24 = r;
        end
    endfunction

    // one merge step: sources OR together, a copy overrides a clear of the same target
    function automatic logic [23:0] bseu_move(input logic [23:0] old, input logic [23:0] src,
                                              input logic copy, input logic clr,
                                              input logic [23:0] m);
        begin
            if (copy) bseu_move = (old & ~m) | (src & m);
            else if (clr) bseu_move = old & ~m;
            else bseu_move = old;
        end
    endfunction

    function automatic bseu_regs_t bseu_regchg(input bseu_regs_t r, input logic [9:0] f,
                                               input logic clr_x);
        bseu_regs_t  n;
        logic [23:0] m;
        logic [23:0] sa;
        logic [23:0] sb;
        logic [23:0] sx;
        begin
            n  = r;
            m  = f[`BSEU_RC_LOW9] ? `BSEU_LOW9_MASK : 24'hFF_FFFF;
            sa = (f[`BSEU_RC_B_TO_A] ? r.b : 24'h00_0000) | (f[`BSEU_RC_X_TO_A] ? r.x : 24'h00_0000)
               | (f[`BSEU_RC_NEG_A] ? (~r.a + 24'h00_0001) : 24'h00_0000);
            sb = (f[`BSEU_RC_A_TO_B] ? r.a : 24'h00_0000) | (f[`BSEU_RC_X_TO_B] ? r.x : 24'h00_0000);
            sx = (f[`BSEU_RC_B_TO_X] ? r.b : 24'h00_0000) | (f[`BSEU_RC_A_TO_X] ? r.a : 24'h00_0000);
            n.a = bseu_move(r.a, sa, f[`BSEU_RC_B_TO_A] | f[`BSEU_RC_X_TO_A] | f[`BSEU_RC_NEG_A],
                            f[`BSEU_RC_CLR_A], m);
            n.b = bseu_move(r.b, sb, f[`BSEU_RC_A_TO_B] | f[`BSEU_RC_X_TO_B], f[`BSEU_RC_CLR_B], m);
            n.x = bseu_move(r.x, sx, f[`BSEU_RC_B_TO_X] | f[`BSEU_RC_A_TO_X], clr_x, m);
            // exponent sign of the new index fills its upper fifteen bits
            if (f[`BSEU_RC_LOW9] && f[`BSEU_RC_B_TO_X]) begin
                n.x = {{15{n.x[`BSEU_XSIGN_BIT]}}, n.x[8:0]};
            end
            bseu_regchg = n;
        end
    endfunction

    bseu_regs_t  regs;
    bseu_regs_t  next_regs;
    bseu_state_t state;
    bseu_state_t next_state;
    bseu_mem_t   mem;
    bseu_mem_t   next_mem;
    logic [23:0] instr;
    logic [23:0] next_instr;
    logic [13:0] ea;
    logic [13:0] next_ea;
    logic [3:0]  cycles;
    logic [3:0]  next_cycles;
    logic        skip;
    logic        next_skip;
    logic        taken;
    logic        next_taken;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        next_int_clear;
    logic        next_int_block;

    logic [5:0]  op;
    logic        is_skip;
    logic        bus_hit;
    logic        skip_cond;
    logic [23:0] inc_index;
    logic [23:0] rtn_word;
    logic [23:0] mark_word;
    logic [7:0]  adr_w;

    assign op        = instr[`BSEU_OP_HI:`BSEU_OP_LO];
    assign is_skip   = (op == OP_SKIP_IF_EQUAL) || (op == OP_SKIP_IF_GREATER)
                    || (op == OP_SKIP_MASKED_EQUAL) || (op == OP_SKIP_NO_COMMON_ONES);
    assign bus_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign adr_w     = {wb_adr_i[7:2], 2'b00};
    assign inc_index = regs.x + 24'h00_0001;
    assign rtn_word  = mem_rdata_i + 24'h00_0001;
    // own address plus status; bits 14, 21 and 22 stay zero
    assign mark_word = {regs.ovf, 2'b00, regs.mem_extension_third, regs.mem_extension_second,
                        1'b0, regs.p};

    always_comb begin
        skip_cond = 1'b0;
        if (op == OP_SKIP_IF_EQUAL) skip_cond = (regs.a == mem_rdata_i);
        else if (op == OP_SKIP_IF_GREATER) skip_cond = ($signed(regs.a) > $signed(mem_rdata_i));
        else if (op == OP_SKIP_MASKED_EQUAL) begin
            skip_cond = (((regs.a ^ mem_rdata_i) & regs.b) == 24'h00_0000);
        end else if (op == OP_SKIP_NO_COMMON_ONES) begin
            skip_cond = ((regs.a & mem_rdata_i) == 24'h00_0000);
        end
    end

    always_comb begin
        next_regs      = regs;
        next_state     = state;
        next_mem       = mem;
        next_instr     = instr;
        next_ea        = ea;
        next_cycles    = cycles;
        next_skip      = skip;
        next_taken     = taken;
        next_dat       = wb_dat_o;
        next_ack       = bus_hit;
        next_int_clear = 1'b0;
        next_int_block = 1'b0;
        if (bus_hit) begin
            case (adr_w)
                `BSEU_OFS_A:      next_dat = {8'h00, regs.a};
                `BSEU_OFS_B:      next_dat = {8'h00, regs.b};
                `BSEU_OFS_X:      next_dat = {8'h00, regs.x};
                `BSEU_OFS_P:      next_dat = {18'h0_0000, regs.p};
                `BSEU_OFS_EA:     next_dat = {18'h0_0000, ea};
                `BSEU_OFS_INSTR:  next_dat = {8'h00, instr};
                `BSEU_OFS_STATUS: next_dat = {20'h0_0000, cycles, 4'h0, taken, skip, regs.ovf,
                                              state != st_idle};
                `BSEU_OFS_EXT:    next_dat = {26'h000_0000, regs.mem_extension_third, regs.mem_extension_second};
                default:          next_dat = 32'h0000_0000;
            endcase
            // writes land only while idle, so software never races the engine
            if (wb_we_i && state == st_idle) begin
                case (adr_w)
                    `BSEU_OFS_A: next_regs.a = bseu_wr24(regs.a, wb_dat_i, wb_sel_i);
                    `BSEU_OFS_B: next_regs.b = bseu_wr24(regs.b, wb_dat_i, wb_sel_i);
                    `BSEU_OFS_X: next_regs.x = bseu_wr24(regs.x, wb_dat_i, wb_sel_i);
                    `BSEU_OFS_P: begin
                        if (wb_sel_i[0]) next_regs.p[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1]) next_regs.p[13:8] = wb_dat_i[13:8];
                    end
                    `BSEU_OFS_EA: begin
                        if (wb_sel_i[0]) next_ea[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1]) next_ea[13:8] = wb_dat_i[13:8];
                    end
                    `BSEU_OFS_INSTR: begin
                        next_instr = bseu_wr24(instr, wb_dat_i, wb_sel_i);
                        next_state = st_decode;
                    end
                    `BSEU_OFS_STATUS: begin
                        if (wb_sel_i[0]) next_regs.ovf = wb_dat_i[1];
                    end
                    `BSEU_OFS_EXT: begin
                        if (wb_sel_i[0]) next_regs.mem_extension_second = wb_dat_i[2:0];
                        if (wb_sel_i[0]) next_regs.mem_extension_third = wb_dat_i[5:3];
                    end
                    default: begin
                    end
                endcase
            end
        end
        case (state)
            st_idle: begin
            end
            st_decode: begin
                next_skip   = 1'b0;
                next_taken  = 1'b0;
                next_cycles = `BSEU_CYC_ONE;
                next_state  = st_idle;
                next_regs.p = regs.p + 14'h0001;
                if (op == `BSEU_OP_REGCHG) begin
                    next_regs = bseu_regchg(regs, instr[9:0], instr[`BSEU_CLRX_BIT]);
                    next_regs.p = regs.p + 14'h0001;
                end else if (op == OP_BRANCH_UNCONDITIONAL) begin
                    next_regs.p    = ea;
                    next_taken     = 1'b1;
                    next_int_clear = instr[`BSEU_IND_BIT];
                end else if (op == OP_INCREMENT_INDEX_BRANCH) begin
                    next_regs.x = inc_index;
                    if (inc_index[`BSEU_INC_INDEX_TEST_BIT]) begin
                        // ea was formed from the index before this increment
                        next_regs.p    = ea;
                        next_taken     = 1'b1;
                        next_int_block = 1'b1;
                    end else begin
                        next_cycles = `BSEU_CYC_TWO;
                    end
                end else if (op == `BSEU_OP_MARK) begin
                    next_regs.p = regs.p;
                    next_mem    = '{req: 1'b1, we: 1'b1, addr: ea, wdata: mark_word};
                    next_state  = st_write;
                end else if (op == `BSEU_OP_RETURN || is_skip) begin
                    next_regs.p = regs.p;
                    next_mem    = '{req: 1'b1, we: 1'b0, addr: ea, wdata: `BSEU_RST_WORD};
                    next_state  = st_read;
                end
            end
            st_read: begin
                if (mem_ack_i) begin
                    next_mem.req = 1'b0;
                    next_state   = st_idle;
                    if (op == `BSEU_OP_RETURN) begin
                        // memory extension bits are not touched here
                        next_regs.p   = rtn_word[13:0];
                        next_regs.ovf = regs.ovf | mem_rdata_i[23];
                        next_taken    = 1'b1;
                        next_cycles   = `BSEU_CYC_TWO;
                    end else if (skip_cond) begin
                        next_regs.p = regs.p + 14'h0002;
                        next_skip   = 1'b1;
                        next_cycles = `BSEU_CYC_THREE;
                    end else begin
                        next_regs.p = regs.p + 14'h0001;
                        next_cycles = `BSEU_CYC_TWO;
                    end
                end
            end
            st_write: begin
                if (mem_ack_i) begin
                    next_mem.req = 1'b0;
                    next_mem.we  = 1'b0;
                    next_regs.p  = ea + 14'h0001;
                    next_taken   = 1'b1;
                    next_cycles  = `BSEU_CYC_TWO;
                    next_state   = st_idle;
                end
            end
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regs        <= '{a: `BSEU_RST_WORD, b: `BSEU_RST_WORD, x: `BSEU_RST_WORD, p: `BSEU_RST_P,
                             ovf: 1'b0, mem_extension_second: 3'h0, mem_extension_third: 3'h0};
            state       <= st_idle;
            mem         <= '{req: 1'b0, we: 1'b0, addr: `BSEU_RST_P, wdata: `BSEU_RST_WORD};
            instr       <= `BSEU_RST_WORD;
            ea          <= `BSEU_RST_P;
            cycles      <= 4'h0;
            skip        <= 1'b0;
            taken       <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
            wb_ack_o    <= 1'b0;
            int_clear_o <= 1'b0;
            int_block_o <= 1'b0;
        end else begin
            regs        <= next_regs;
            state       <= next_state;
            mem         <= next_mem;
            instr       <= next_instr;
            ea          <= next_ea;
            cycles      <= next_cycles;
            skip        <= next_skip;
            taken       <= next_taken;
            wb_dat_o    <= next_dat;
            wb_ack_o    <= next_ack;
            int_clear_o <= next_int_clear;
            int_block_o <= next_int_block;
        end
    end

    assign mem_req_o   = mem.req;
    assign mem_we_o    = mem.we;
    assign mem_addr_o  = mem.addr;
    assign mem_wdata_o = mem.wdata;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_regchg_one_cycle:
    assert property (state == st_decode && op == `BSEU_OP_REGCHG |=> state == st_idle
                     && cycles == `BSEU_CYC_ONE && regs.p == $past(regs.p) + 14'h0001)
        else $error("register change did not finish in one cycle");

    a_exponent_exchange:
    assert property (state == st_decode && op == `BSEU_OP_REGCHG && instr[9:0] == `BSEU_RC_EXCHANGE_EXPONENTS
                     |=> regs.b == {$past(regs.b[23:9]), $past(regs.x[8:0])}
                     && regs.x == {{15{$past(regs.b[8])}}, $past(regs.b[8:0])})
        else $error("exponent exchange result wrong");

    a_negate_a:
    assert property (state == st_decode && op == `BSEU_OP_REGCHG && instr[9:0] == `BSEU_RC_NEGATE_A_COPY
                     |=> regs.a == ~$past(regs.a) + 24'h00_0001)
        else $error("negate A result wrong");

    a_branch_target:
    assert property (state == st_decode && op == OP_BRANCH_UNCONDITIONAL
                     |=> regs.p == $past(ea) && state == st_idle)
        else $error("unconditional branch target wrong");

    a_int_clear_pulse:
    assert property (int_clear_o == $past(state == st_decode && op == OP_BRANCH_UNCONDITIONAL
                                          && instr[`BSEU_IND_BIT]))
        else $error("interrupt clear pulse wrong");

    a_index_branch:
    assert property (state == st_decode && op == OP_INCREMENT_INDEX_BRANCH |=> regs.x == $past(inc_index)
                     && regs.p == ($past(inc_index[14]) ? $past(ea) : $past(regs.p) + 14'h0001)
                     && cycles == ($past(inc_index[14]) ? `BSEU_CYC_ONE : `BSEU_CYC_TWO))
        else $error("increment index and branch wrong");

    a_int_block_pulse:
    assert property (int_block_o == $past(state == st_decode && op == OP_INCREMENT_INDEX_BRANCH
                                          && inc_index[14]))
        else $error("interrupt block pulse wrong");

    a_mark_word:
    assert property (state == st_write |-> mem_req_o && mem_we_o && mem_addr_o == ea
                     && mem_wdata_o == {regs.ovf, 2'b00, regs.mem_extension_third,
                                        regs.mem_extension_second, 1'b0, regs.p})
        else $error("mark place word wrong");

    a_return_branch:
    assert property (state == st_read && mem_ack_i && op == `BSEU_OP_RETURN
                     |=> regs.p == $past(mem_rdata_i[13:0]) + 14'h0001
                     && regs.ovf == ($past(regs.ovf) | $past(mem_rdata_i[23]))
                     && regs.mem_extension_second == $past(regs.mem_extension_second)
                     && regs.mem_extension_third == $past(regs.mem_extension_third))
        else $error("return branch wrong");

    a_skip_result:
    assert property (state == st_read && mem_ack_i && is_skip
                     |=> skip == $past(skip_cond) && regs.a == $past(regs.a)
                     && cycles == ($past(skip_cond) ? `BSEU_CYC_THREE : `BSEU_CYC_TWO)
                     && regs.p == $past(regs.p) + ($past(skip_cond) ? 14'h0002 : 14'h0001))
        else $error("skip timing or resume address wrong");

endmodule

// ---- bseu_consts.svh ----
// constants for the branch, skip and register-change execution unit
`ifndef BSEU_CONSTS_SVH
`define BSEU_CONSTS_SVH
`define BSEU_OFS_A          8'h00
`define BSEU_OFS_B          8'h04
`define BSEU_OFS_X          8'h08
`define BSEU_OFS_P          8'h0C
`define BSEU_OFS_EA         8'h10
`define BSEU_OFS_INSTR      8'h14
`define BSEU_OFS_STATUS     8'h18
`define BSEU_OFS_EXT        8'h1C
`define BSEU_OP_HI          20
`define BSEU_OP_LO          15
`define BSEU_IND_BIT        21
`define BSEU_CLRX_BIT       22
`define BSEU_OP_REGCHG      6'h26
`define BSEU_OP_MARK        6'h23
`define BSEU_OP_RETURN      6'h29
`define BSEU_RC_CLR_A       0
`define BSEU_RC_CLR_B       1
`define BSEU_RC_A_TO_B      2
`define BSEU_RC_B_TO_A      3
`define BSEU_RC_B_TO_X      4
`define BSEU_RC_X_TO_B      5
`define BSEU_RC_LOW9        6
`define BSEU_RC_X_TO_A      7
`define BSEU_RC_A_TO_X      8
`define BSEU_RC_NEG_A       9
`define BSEU_RC_EXCHANGE_EXPONENTS 10'h070
`define BSEU_RC_NEGATE_A_COPY      10'h200
`define BSEU_LOW9_MASK      24'h00_01FF
`define BSEU_INC_INDEX_TEST_BIT 14
`define BSEU_XSIGN_BIT      8
`define BSEU_CYC_ONE        4'h1
`define BSEU_CYC_TWO        4'h2
`define BSEU_CYC_THREE      4'h3
`define BSEU_RST_WORD       24'h00_0000
`define BSEU_RST_P          14'h0000
`endif

// ---- bseu_pkg.sv ----
// types for the branch, skip and register-change execution unit
package bseu_pkg;
    typedef struct packed {
        logic [23:0] a;
        logic [23:0] b;
        logic [23:0] x;
        logic [13:0] p;
        logic        ovf;
        logic [2:0]  mem_extension_second;
        logic [2:0]  mem_extension_third;
    } bseu_regs_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [13:0] addr;
        logic [23:0] wdata;
    } bseu_mem_t;

    typedef enum logic [3:0] {
        st_idle   = 4'b0001,
        st_decode = 4'b0010,
        st_read   = 4'b0100,
        st_write  = 4'b1000
    } bseu_state_t;
endpackage

// ---- bseu_mem_model.sv ----
// main memory model answering the execution unit's fetch and store requests
`timescale 1ns/1ns
module bseu_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [13:0] addr_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic [3:0]  lat_i,
    output logic             ack_o,
    output logic      [23:0] rdata_o
);
    logic [23:0] mem [0:16383];
    logic [3:0]  wait_cnt;
    logic        gap;

    // plain always so the bench may preload words between instructions
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o    <= 1'b0;
            wait_cnt <= 4'h0;
            gap      <= 1'b0;
            rdata_o  <= 24'h5A_5A5A;
        end else begin
            gap     <= ack_o;
            ack_o   <= 1'b0;
            // data lines wander outside the ack cycle, never a stale match
            rdata_o <= ~rdata_o;
            // a write lands at the edge that samples ack, request still held
            if (ack_o && we_i) begin
                mem[addr_i] <= wdata_i;
            end
            if (req_i && !ack_o && !gap) begin
                if (wait_cnt >= lat_i) begin
                    ack_o    <= 1'b1;
                    wait_cnt <= 4'h0;
                    rdata_o  <= mem[addr_i];
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the branch, skip and register-change execution unit
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [23:0] a, b, x, ins, m, ra, rb, rx;
        logic [13:0] ep;
        logic [11:0] st;
    } bseu_row_t;
    localparam logic [23:0] Z = 24'h00_0000, EXCH_EXP = 24'h13_0070, NEG_A = 24'h13_0200, BR_UNCOND = 24'h00_8000;
    localparam logic [23:0] BR_INC_X = 24'h10_8000, BR_MARK = 24'h11_8000, BR_RETURN = 24'h14_8000;
    localparam logic [23:0] SKIP_EQ = 24'h14_0000, SKIP_GT = 24'h1D_8000, SKIP_MASK = 24'h1C_0000;
    localparam logic [23:0] SKIP_NONE = 24'h1D_0000;
    logic        clk_i, rst_i, cyc, stb, we, ack, mreq, mwe, mack, iclr, iblk;
    logic [7:0]  adr;
    logic [3:0]  sel, lat;
    logic [31:0] wdat, rdat, q, st;
    logic [13:0] maddr;
    logic [23:0] mwdata, mrdata;
    int          n_errors, checked, cycles, n_clr, n_blk;
    // prompt memory, P = 0100, EA = 0522 for every row
    bseu_row_t rows [17] = '{
        '{Z, 24'h12_3456, 24'hFF_FF1B, EXCH_EXP, Z, Z, 24'h12_351B, 24'h00_0056, 14'h0101, 12'h100},
        '{Z, 24'h00_0133, Z, EXCH_EXP, Z, Z, Z, 24'hFF_FF33, 14'h0101, 12'h100},
        '{24'h00_0005, Z, Z, NEG_A, Z, 24'hFF_FFFB, Z, Z, 14'h0101, 12'h100},
        '{Z, Z, Z, BR_UNCOND, Z, Z, Z, Z, 14'h0522, 12'h100},
        '{Z, Z, 24'hFF_FFFF, BR_INC_X, Z, Z, Z, Z, 14'h0101, 12'h200},
        '{Z, Z, 24'h00_3FFF, BR_INC_X, Z, Z, Z, 24'h00_4000, 14'h0522, 12'h100},
        '{Z, Z, Z, BR_MARK, Z, Z, Z, Z, 14'h0523, 12'h200},
        '{Z, Z, Z, BR_RETURN, 24'h80_3220, Z, Z, Z, 14'h3221, 12'h202},
        '{24'h12_3456, Z, Z, SKIP_EQ, 24'h12_3456, 24'h12_3456, Z, Z, 14'h0102, 12'h304},
        '{24'h12_3456, Z, Z, SKIP_EQ, 24'h12_3457, 24'h12_3456, Z, Z, 14'h0101, 12'h200},
        '{24'h00_0001, Z, Z, SKIP_GT, 24'hFF_FFFF, 24'h00_0001, Z, Z, 14'h0102, 12'h304},
        '{24'h00_0005, Z, Z, SKIP_GT, 24'h00_0005, 24'h00_0005, Z, Z, 14'h0101, 12'h200},
        '{24'h00_0001, Z, Z, SKIP_MASK, 24'h00_0002, 24'h00_0001, Z, Z, 14'h0102, 12'h304},
        '{24'h00_00A5, 24'h00_00F0, Z, SKIP_MASK, 24'h00_00A3, 24'h00_00A5, 24'h00_00F0, Z, 14'h0102, 12'h304},
        '{24'h00_00A5, 24'h00_00F0, Z, SKIP_MASK, 24'h00_00B5, 24'h00_00A5, 24'h00_00F0, Z, 14'h0101, 12'h200},
        '{24'h00_00F0, Z, Z, SKIP_NONE, 24'h00_000F, 24'h00_00F0, Z, Z, 14'h0102, 12'h304},
        '{24'h00_00F0, Z, Z, SKIP_NONE, 24'h00_0010, 24'h00_00F0, Z, Z, 14'h0101, 12'h200}
    };

    bseu_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwdata),
        .mem_ack_i(mack), .mem_rdata_i(mrdata), .int_clear_o(iclr), .int_block_o(iblk));
    bseu_mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
        .wdata_i(mwdata), .lat_i(lat), .ack_o(mack), .rdata_o(mrdata));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic complete_run();
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // pulses are single cycles, so each high sample is one event
    always @(posedge clk_i) begin
        cycles++;
        if (iclr === 1'b1) n_clr++;
        if (iblk === 1'b1) n_blk++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [23:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {8'h00, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        logic [31:0] unused;
        wb(1'b1, a, d, unused);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        wb(1'b0, a, Z, r);
    endtask

    task automatic wait_idle();
        do rd(8'h18, st); while (st[0] !== 1'b0);
    endtask

    initial begin
        rst_i = 1'b1;
        cyc   = 1'b0;
        stb   = 1'b0;
        we    = 1'b0;
        adr   = 8'h00;
        sel   = 4'hF;
        wdat  = 32'h0000_0000;
        lat   = 4'h0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(8'h1C, 24'h00_001A);
        foreach (rows[i]) begin
            wr(8'h00, rows[i].a);
            wr(8'h04, rows[i].b);
            wr(8'h08, rows[i].x);
            wr(8'h0C, 24'h00_0100);
            wr(8'h10, 24'h00_0522);
            wr(8'h18, Z);
            mdl.mem[14'h0522] = rows[i].m;
            wr(8'h14, rows[i].ins);
            wait_idle();
            chk(st & 32'h0000_0F06, {20'h0_0000, rows[i].st});
            rd(8'h00, q); chk(q, {8'h00, rows[i].ra});
            rd(8'h04, q); chk(q, {8'h00, rows[i].rb});
            rd(8'h08, q); chk(q, {8'h00, rows[i].rx});
            rd(8'h0C, q); chk(q, {18'h0_0000, rows[i].ep});
            chk({8'h00, mdl.mem[14'h0522]}, {8'h00, rows[i].ins == BR_MARK ? 24'h0D_0100 : rows[i].m});
        end
        rd(8'h1C, q); chk(q, 32'h0000_001A);
        chk(n_blk, 1);
        chk(n_clr, 0);
        wr(8'h14, BR_UNCOND | 24'h20_0000);
        wait_idle();
        chk(n_clr, 1);
        // slow memory, overflow set, and a write of A refused while busy
        lat <= 4'h6;
        wr(8'h18, 24'h00_0002);
        wr(8'h00, 24'h00_0077);
        wr(8'h0C, 24'h00_0100);
        wr(8'h10, 24'h00_0600);
        wr(8'h14, BR_MARK);
        wr(8'h00, 24'h00_0055);
        wait_idle();
        rd(8'h00, q); chk(q, 32'h0000_0077);
        chk({8'h00, mdl.mem[14'h0600]}, 32'h008D_0100);
        rd(8'h0C, q); chk(q, 32'h0000_0601);
        rd(8'h40, q); chk(q, 32'h0000_0000);
        // second reset in mid-run clears the register file
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            rd(8'(k * 4), q);
            chk(q, 32'h0000_0000);
        end
        complete_run();
    end
endmodule
